// [rtl/alu_regs.vh]
/*
  Constants of the 8-bit arithmetic and logic datapath: operation codes,
  operand forms, widths and reset values.
  Assumes it is included by the datapath module only, by its bare name.
*/
// Operation
// - Rotate right through carry, old carry to bit7
// - Arithmetic right shift keeps bit7, bit0 to carry
// - Ones complement, only zero flag changes
// - Twos complement, carry set when result zero
// - Complement plus carry, carry when zero and carry
// - Increment, carry set when result wraps zero
// - Increment by carry, carry when zero and carry
// - Decrement, carry cleared when result is FF
// - Decrement with borrow, clear on FF without carry
// - AND of sources, only zero flag, all forms
// - OR of sources, only zero flag changes
// - XOR of sources, only zero flag changes
// - Add, carry set on unsigned overflow
// - Add with carry, chainable unsigned carry out
// - Direct subtract, carry cleared on underflow
// - Direct subtract with borrow, same operand order
// - Swapped subtract, reverse order, carry on no-underflow
// - Swapped subtract with borrow, carry cleared on underflow
// - Memory form reads operand, writes register and accumulator
// - Zero flag follows accumulator after updating operations
// - Overflow flag marks signed range overflow
`ifndef ALU_REGS_VH
`define ALU_REGS_VH

// Data and address widths
`define ALU_DATA_W 8
`define ALU_ADDR_W 16

// Operation codes on OPCODE
`define ALU_OP_ROTR_CARRY 5'h00
`define ALU_OP_SHIFT_ARITH 5'h01
`define ALU_OP_ONES_COMPLEMENT 5'h02
`define ALU_OP_TWOS_COMPLEMENT 5'h03
`define ALU_OP_COMPLEMENT_WITH_CARRY 5'h04
`define ALU_OP_INCREMENT 5'h05
`define ALU_OP_INCREMENT_CARRY 5'h06
`define ALU_OP_DECREMENT 5'h07
`define ALU_OP_DECREMENT_BORROW 5'h08
`define ALU_OP_AND 5'h09
`define ALU_OP_OR 5'h0A
`define ALU_OP_XOR 5'h0B
`define ALU_OP_ADD 5'h0C
`define ALU_OP_ADD_CARRY 5'h0D
`define ALU_OP_SUB_DIRECT 5'h0E
`define ALU_OP_SUB_DIRECT_BORROW 5'h0F
`define ALU_OP_SUB_SWAP 5'h10
`define ALU_OP_SUB_SWAP_BORROW 5'h11

// Operand forms on FORM
`define ALU_FORM_THREE_REG 3'h0
`define ALU_FORM_TWO_REG 3'h1
`define ALU_FORM_ONE_REG 3'h2
`define ALU_FORM_IMMEDIATE 3'h3
`define ALU_FORM_MEMORY 3'h4

// Reset values
`define ALU_RST_DATA 8'h00
`define ALU_RST_FLAG 1'b0
`define ALU_RST_OP 5'h00
`define ALU_RST_ADDR 16'h0000

`endif

// [rtl/alu_core.v]
/*
  Eight-bit arithmetic and logic datapath with its carry, overflow and zero
  flags, the accumulator and a small sequencer for memory operands.
  Assumes the instruction decoder on the same clock holds OPCODE, FORM and
  the operands steady in the cycle of START, and that data memory answers
  MEM_RD with MEM_RDATA valid in the cycle after MEM_RD is high.
*/
`timescale 1ns/1ps
`default_nettype none
`include "alu_regs.vh"

module alu_core (
  input  wire        CORE_CLK,
  input  wire        ARST_N,
  input  wire        START,
  input  wire [4:0]  OPCODE,
  input  wire [2:0]  FORM,
  input  wire [7:0]  REG_A,
  input  wire [7:0]  REG_B,
  input  wire [7:0]  IMM_DATA,
  input  wire [15:0] EADDR,
  input  wire [7:0]  MEM_RDATA,
  output reg         MEM_RD,
  output reg  [15:0] MEM_ADDR,
  output reg  [7:0]  ACC,
  output reg  [7:0]  DEST_DATA,
  output reg         DEST_WE,
  output reg         FLAG_C,
  output reg         FLAG_V,
  output reg         FLAG_Z,
  output wire        BUSY,
  output reg         DONE,
  output reg         BAD_OP
);

  // Sequencer states. EXEC is the single write cycle of every form, so
  // results and flags always change at one and the same edge.
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_MEM  = 2'b01;
  localparam [1:0] ST_CAP  = 2'b10;
  localparam [1:0] ST_EXEC = 2'b11;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [4:0]  op_q;
  reg  [2:0]  form_q;
  reg  [7:0]  rega_q;
  reg  [7:0]  regb_q;
  reg  [7:0]  imm_q;
  reg  [7:0]  mem_q;

  // Operand routing results
  reg  [7:0]  left;
  reg  [7:0]  right;
  reg  [7:0]  src;

  // Compute results
  reg  [7:0]  next_res;
  reg         next_c;
  reg         next_v;
  reg         upd_cv;
  reg         op_ok;
  reg  [9:0]  sum;

  // One adder serves every arithmetic operation; returns {v, carry, sum}.
  // Overflow is the usual two's complement test on the operands added.
  function [9:0] alu_add;
    input [7:0] a;
    input [7:0] b;
    input       cin;
    reg   [8:0] s;
    begin
      s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      alu_add = {(a[7] == b[7]) && (s[7] != a[7]), s[8], s[7:0]};
    end
  endfunction

  // Memory-operand decode, shared by the sequencer and the capture stage
  // so that both always agree on which requests fetch from memory.
  function is_mem_form;
    input [2:0] f;
    begin
      is_mem_form = (f == `ALU_FORM_MEMORY);
    end
  endfunction

  // Busy straight from the state: a START in the answer cycle is taken,
  // which gives the decoder back-to-back requests without a gap.
  assign BUSY = (state != ST_IDLE);

  // Operand order per form: direct subtract is left minus right.
  // Three registers: reg2 - reg3; two registers: reg2 - reg1;
  // immediate: data - reg; memory: memory - reg.
  always @* begin
    right = regb_q;
    case (form_q)
      `ALU_FORM_THREE_REG: begin
        left = rega_q;
        src  = rega_q;
      end
      `ALU_FORM_TWO_REG: begin
        left = rega_q;
        src  = rega_q;
      end
      `ALU_FORM_ONE_REG: begin
        left = rega_q;
        src  = regb_q;
      end
      `ALU_FORM_IMMEDIATE: begin
        left = imm_q;
        src  = regb_q;
      end
      `ALU_FORM_MEMORY: begin
        left = mem_q;
        src  = mem_q;
      end
      default: begin
        left = rega_q;
        src  = rega_q;
      end
    endcase
  end

  // Operation decode. Carry and overflow keep their value unless upd_cv.
  // Every arithmetic case goes through the one adder; a borrow is handled
  // as an inverted operand plus carry, so carry out means "no borrow".
  always @* begin
    next_res = 8'h00;
    next_c   = FLAG_C;
    next_v   = FLAG_V;
    upd_cv   = 1'b1;
    op_ok    = 1'b1;
    sum      = 10'h000;
    case (op_q)
      `ALU_OP_ROTR_CARRY: begin
        next_res = {FLAG_C, src[7:1]};
        next_c   = src[0];
        next_v   = FLAG_C ^ src[7];                      // Sign changed by the rotate
      end
      `ALU_OP_SHIFT_ARITH: begin
        next_res = {src[7], src[7:1]};
        next_c   = src[0];
        next_v   = 1'b0;                                 // Sign always kept
      end
      `ALU_OP_ONES_COMPLEMENT: begin
        next_res = ~src;
        upd_cv   = 1'b0;
      end
      `ALU_OP_TWOS_COMPLEMENT: begin
        sum = alu_add(~src, 8'h00, 1'b1);                // Carry out means result zero
      end
      `ALU_OP_COMPLEMENT_WITH_CARRY: begin
        sum = alu_add(~src, 8'h00, FLAG_C);
      end
      `ALU_OP_INCREMENT: begin
        sum = alu_add(src, 8'h00, 1'b1);                 // Carry out on wrap to zero
      end
      `ALU_OP_INCREMENT_CARRY: begin
        sum = alu_add(src, 8'h00, FLAG_C);
      end
      `ALU_OP_DECREMENT: begin
        sum = alu_add(src, 8'hFF, 1'b0);                 // No carry only when result is FF
      end
      `ALU_OP_DECREMENT_BORROW: begin
        sum = alu_add(src, 8'hFF, FLAG_C);               // src - (1 - C)
      end
      `ALU_OP_AND: begin
        next_res = left & right;
        upd_cv   = 1'b0;
      end
      `ALU_OP_OR: begin
        next_res = left | right;
        upd_cv   = 1'b0;
      end
      `ALU_OP_XOR: begin
        next_res = left ^ right;
        upd_cv   = 1'b0;
      end
      `ALU_OP_ADD: begin
        sum = alu_add(left, right, 1'b0);
      end
      `ALU_OP_ADD_CARRY: begin
        sum = alu_add(left, right, FLAG_C);
      end
      `ALU_OP_SUB_DIRECT: begin
        sum = alu_add(left, ~right, 1'b1);               // Carry out is "no borrow"
      end
      `ALU_OP_SUB_DIRECT_BORROW: begin
        sum = alu_add(left, ~right, FLAG_C);             // left - right - (1 - C)
      end
      `ALU_OP_SUB_SWAP: begin
        sum = alu_add(right, ~left, 1'b1);
      end
      `ALU_OP_SUB_SWAP_BORROW: begin
        sum = alu_add(right, ~left, FLAG_C);
      end
      default: begin
        op_ok  = 1'b0;
        upd_cv = 1'b0;
      end
    endcase
    // Arithmetic cases land here through the shared adder
    if (op_ok && upd_cv && (op_q != `ALU_OP_ROTR_CARRY) && (op_q != `ALU_OP_SHIFT_ARITH)) begin
      next_res = sum[7:0];
      next_c   = sum[8];
      next_v   = sum[9];
    end
  end

  // Sequencer: memory forms spend two extra cycles on the read so the
  // decoder never has to hold the operand itself.
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (START) begin
          if (is_mem_form(FORM)) begin
            next_state = ST_MEM;
          end else begin
            next_state = ST_EXEC;
          end
        end
      end
      ST_MEM: begin
        next_state = ST_CAP;
      end
      ST_CAP: begin
        next_state = ST_EXEC;
      end
      ST_EXEC: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Operand capture and memory strobe. START while busy is ignored.
  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state    <= ST_IDLE;
      op_q     <= `ALU_RST_OP;
      form_q   <= `ALU_FORM_THREE_REG;
      rega_q   <= `ALU_RST_DATA;
      regb_q   <= `ALU_RST_DATA;
      imm_q    <= `ALU_RST_DATA;
      mem_q    <= `ALU_RST_DATA;
      MEM_RD   <= 1'b0;
      MEM_ADDR <= `ALU_RST_ADDR;
    end else begin
      state  <= next_state;
      // Strobe is a one-cycle pulse; the address stays for the next read
      MEM_RD <= 1'b0;
      if ((state == ST_IDLE) && START) begin
        op_q   <= OPCODE;
        form_q <= FORM;
        rega_q <= REG_A;
        regb_q <= REG_B;
        imm_q  <= IMM_DATA;
        if (is_mem_form(FORM)) begin
          MEM_RD   <= 1'b1;
          MEM_ADDR <= EADDR;
        end
      end
      // Memory answers one cycle after the strobe; a slower memory would
      // need a wait input here, which this block does not offer.
      if (state == ST_CAP) begin
        mem_q <= MEM_RDATA;
      end
    end
  end

  // Result write: accumulator, destination and flags together at one edge.
  // An unknown code writes nothing and reports BAD_OP with DONE.
  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ACC       <= `ALU_RST_DATA;
      DEST_DATA <= `ALU_RST_DATA;
      DEST_WE   <= 1'b0;
      FLAG_C    <= `ALU_RST_FLAG;
      FLAG_V    <= `ALU_RST_FLAG;
      FLAG_Z    <= `ALU_RST_FLAG;
      DONE      <= 1'b0;
      BAD_OP    <= 1'b0;
    end else begin
      DEST_WE <= 1'b0;
      DONE    <= 1'b0;
      BAD_OP  <= 1'b0;
      if (state == ST_EXEC) begin
        DONE <= 1'b1;
        if (op_ok) begin
          ACC       <= next_res;
          DEST_DATA <= next_res;
          DEST_WE   <= 1'b1;
          FLAG_Z    <= (next_res == 8'h00);
          // Logic and ones complement leave carry and overflow alone
          if (upd_cv) begin
            FLAG_C <= next_c;
            FLAG_V <= next_v;
          end
        end else begin
          // Nothing is written, so a stray code cannot corrupt a chain
          BAD_OP <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// [tb/alu_mem_model.sv]
/* Data memory partner: answers a read strobe one cycle later.
   Assumes the strobe is a one-cycle pulse on the core clock. */
`timescale 1ns/1ps
`default_nettype none
module alu_mem_model (
  input  wire logic        clk,
  input  wire logic        rd,
  input  wire logic [15:0] addr,
  output var  logic [7:0]  rdata
);
  logic take;
  initial rdata = 8'h3C;
  // Off-cycle the bus toggles so a late sample never looks valid
  always @(posedge clk) begin
    take = rd;
    #1;
    if (take) rdata = addr[7:0] ^ 8'hA5;
    else rdata = ~rdata;
  end
endmodule
`default_nettype wire

// [tb/alu_core_asserts.sv]
/* Port assertions of the datapath.
   Assumes a single clock domain and binding onto alu_core. */
`timescale 1ns/1ps
`default_nettype none
module alu_core_asserts (
  input wire logic        CORE_CLK,
  input wire logic        ARST_N,
  input wire logic        START,
  input wire logic [4:0]  OPCODE,
  input wire logic [2:0]  FORM,
  input wire logic [7:0]  REG_A,
  input wire logic [15:0] EADDR,
  input wire logic        MEM_RD,
  input wire logic [15:0] MEM_ADDR,
  input wire logic [7:0]  ACC,
  input wire logic [7:0]  DEST_DATA,
  input wire logic        DEST_WE,
  input wire logic        FLAG_C,
  input wire logic        FLAG_V,
  input wire logic        FLAG_Z,
  input wire logic        BUSY,
  input wire logic        DONE,
  input wire logic        BAD_OP
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  wire logic take;
  // A request counts only while idle
  assign take = START && !BUSY;
  chk_reg_answer: assert property (take && FORM != 3'h4 |=> BUSY ##1 (DONE && !BUSY))
    else $error("register form answer out of time");
  chk_mem_fetch: assert property (take && FORM == 3'h4 |=>
    (MEM_RD && MEM_ADDR == $past(EADDR)) ##1 !MEM_RD ##2 DONE)
    else $error("memory form fetch out of order");
  chk_write_both: assert property (DEST_WE |-> DONE && !BAD_OP && DEST_DATA == ACC)
    else $error("destination and accumulator differ");
  chk_bad_keeps: assert property (BAD_OP |->
    DONE && !DEST_WE && $stable({ACC, FLAG_C, FLAG_V, FLAG_Z}))
    else $error("unknown operation changed state");
  chk_zero_flag: assert property (DONE && !BAD_OP |-> FLAG_Z == (ACC == 8'h00))
    else $error("zero flag does not follow accumulator");
  chk_idle_hold: assert property (!DONE |->
    $stable({ACC, DEST_DATA, FLAG_C, FLAG_V, FLAG_Z}))
    else $error("result changed outside completion");
  chk_rotate_carry: assert property (take && OPCODE == 5'h00 && FORM == 3'h0 |->
    ##2 {ACC, FLAG_C} == {$past(FLAG_C, 2), $past(REG_A, 2)})
    else $error("rotate through carry wrong");
  chk_shift_sign: assert property (take && OPCODE == 5'h01 && FORM == 3'h0 |->
    ##2 ({ACC[6:0], FLAG_C} == $past(REG_A, 2) && ACC[7] == ACC[6]))
    else $error("arithmetic shift wrong");
  chk_invert_keeps: assert property (take && OPCODE == 5'h02 && FORM == 3'h0 |->
    ##2 (ACC == ~$past(REG_A, 2) && $stable({FLAG_C, FLAG_V})))
    else $error("ones complement wrong");
endmodule
bind alu_core alu_core_asserts u_alu_core_asserts (
  .CORE_CLK  (CORE_CLK),
  .ARST_N    (ARST_N),
  .START     (START),
  .OPCODE    (OPCODE),
  .FORM      (FORM),
  .REG_A     (REG_A),
  .EADDR     (EADDR),
  .MEM_RD    (MEM_RD),
  .MEM_ADDR  (MEM_ADDR),
  .ACC       (ACC),
  .DEST_DATA (DEST_DATA),
  .DEST_WE   (DEST_WE),
  .FLAG_C    (FLAG_C),
  .FLAG_V    (FLAG_V),
  .FLAG_Z    (FLAG_Z),
  .BUSY      (BUSY),
  .DONE      (DONE),
  .BAD_OP    (BAD_OP)
);
`default_nettype wire

// [tb/cpu_alu_shift_arith_logic_tb.sv]
/* Self-checking bench: every operation in every operand form with
   corner and random operands; a monitor pairs results with expectations.
   Assumes alu_core, the memory model and the checker are compiled. */
`timescale 1ns/1ps
`default_nettype none
module cpu_alu_shift_arith_logic_tb;
  logic        CORE_CLK, ARST_N, START, MEM_RD, DEST_WE, BUSY, DONE, BAD_OP;
  logic        FLAG_C, FLAG_V, FLAG_Z;
  logic [4:0]  OPCODE;
  logic [2:0]  FORM;
  logic [7:0]  REG_A, REG_B, IMM_DATA, MEM_RDATA, ACC, DEST_DATA, m_acc;
  logic [15:0] EADDR, MEM_ADDR;
  logic [31:0] seed;
  logic [11:0] exp_q[$];
  logic [11:0] e_top;
  logic [23:0] m_got, m_exp, r_got;
  logic        m_c, m_v, m_z;
  integer      bad_count, cmp_count;

  alu_core u_alu_core (
    .CORE_CLK  (CORE_CLK),
    .ARST_N    (ARST_N),
    .START     (START),
    .OPCODE    (OPCODE),
    .FORM      (FORM),
    .REG_A     (REG_A),
    .REG_B     (REG_B),
    .IMM_DATA  (IMM_DATA),
    .EADDR     (EADDR),
    .MEM_RDATA (MEM_RDATA),
    .MEM_RD    (MEM_RD),
    .MEM_ADDR  (MEM_ADDR),
    .ACC       (ACC),
    .DEST_DATA (DEST_DATA),
    .DEST_WE   (DEST_WE),
    .FLAG_C    (FLAG_C),
    .FLAG_V    (FLAG_V),
    .FLAG_Z    (FLAG_Z),
    .BUSY      (BUSY),
    .DONE      (DONE),
    .BAD_OP    (BAD_OP)
  );
  alu_mem_model u_alu_mem_model (.clk(CORE_CLK), .rd(MEM_RD), .addr(MEM_ADDR), .rdata(MEM_RDATA));

  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Corner values 00, 7F, 80, FF half of the time, random otherwise
  function [7:0] pick(input [9:0] r);
    pick = r[0] ? r[8:1] : {r[1], {7{r[2]}}};
  endfunction
  // Result {acc, C, V, Z}; every arithmetic case is one adder x + y + ci
  function [10:0] ref_op(input [4:0] op, input [7:0] l, r, s, input c, v);
    logic [7:0] x, y;
    logic [8:0] t;
    logic       ci, m;
    begin
      m = 0; x = s; y = 8'h00; ci = c;
      case (op)
        5'h00: begin m = 1; t = {s[0], c, s[7:1]}; v = c ^ s[7]; end
        5'h01: begin m = 1; t = {s[0], s[7], s[7:1]}; v = 1'b0; end
        5'h02: begin m = 1; t = {c, ~s}; end
        5'h03: begin x = ~s; ci = 1'b1; end
        5'h04: x = ~s;
        5'h05: ci = 1'b1;
        5'h06: ;
        5'h07: begin y = 8'hFF; ci = 1'b0; end
        5'h08: y = 8'hFF;
        5'h09: begin m = 1; t = {c, l & r}; end
        5'h0A: begin m = 1; t = {c, l | r}; end
        5'h0B: begin m = 1; t = {c, l ^ r}; end
        5'h0C: begin x = l; y = r; ci = 1'b0; end
        5'h0D: begin x = l; y = r; end
        5'h0E: begin x = l; y = ~r; ci = 1'b1; end
        5'h0F: begin x = l; y = ~r; end
        5'h10: begin x = r; y = ~l; ci = 1'b1; end
        default: begin x = r; y = ~l; end
      endcase
      if (!m) begin
        t = x + y + ci;
        v = (x[7] == y[7]) && (t[7] != x[7]);
      end
      // Counting carries as the rules word them, not as an adder carry
      if (op >= 5'h03 && op <= 5'h06) begin
        t[8] = (t[7:0] == 8'h00) && ci;
      end
      if (op == 5'h07 || op == 5'h08) begin
        t[8] = !((t[7:0] == 8'hFF) && !ci);
      end
      ref_op = {t[7:0], t[8], v, t[7:0] == 8'h00};
    end
  endfunction

  task check(input [23:0] got, input [23:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  // Drives one request, notes its result, waits for completion
  task issue(input [4:0] op, input [2:0] f, input [7:0] a, b, im, input [15:0] ad);
    logic [7:0]  l, s;
    logic [10:0] e;
    logic        bad;
    integer      n;
    begin
      l = (f == 3'h3) ? im : (f == 3'h4) ? ad[7:0] ^ 8'hA5 : a;
      s = (f == 3'h4) ? l : (f >= 3'h2) ? b : a;
      bad = (op > 5'h11);
      e = bad ? {m_acc, m_c, m_v, m_z} : ref_op(op, l, b, s, m_c, m_v);
      {m_acc, m_c, m_v, m_z} = e;
      exp_q.push_back({bad, e});
      {OPCODE, FORM, REG_A, REG_B, IMM_DATA, EADDR} = {op, f, a, b, im, ad};
      START = 1'b1;
      @(posedge CORE_CLK) #1 START = 1'b0;
      n = 0;
      while (DONE !== 1'b1 && n < 8) begin
        @(posedge CORE_CLK) #1 n = n + 1;
      end
      if (DONE !== 1'b1) check(24'h0, 24'h1);
    end
  endtask

  task conclude;
    begin
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  initial begin
    CORE_CLK = 1'b0;
    forever #10 CORE_CLK = ~CORE_CLK;
  end

  // Monitor: each completion takes the oldest expectation
  always @(posedge CORE_CLK) begin
    #2;
    if (DONE === 1'b1 && exp_q.size() > 0) begin
      e_top = exp_q.pop_front();
      // Destination always shows the last written result, as ACC does
      m_got = {3'h0, BAD_OP, DEST_WE, DEST_DATA, ACC, FLAG_C, FLAG_V, FLAG_Z};
      m_exp = {3'h0, e_top[11], !e_top[11], e_top[10:3], e_top[10:0]};
      check(m_got, m_exp);
    end else if (DONE === 1'b1) begin
      check(24'h0, 24'h1);
    end
  end

  // Watchdog sized well beyond the roughly 870 cycles of traffic
  initial begin
    #(20 * 6000);
    bad_count = bad_count + 1;
    conclude;
  end

  initial begin
    {ARST_N, START, OPCODE, FORM, REG_A, REG_B, IMM_DATA, EADDR} = 0;
    {m_acc, m_c, m_v, m_z} = 0;
    bad_count = 0;
    cmp_count = 0;
    seed = 32'hEB65;
    repeat (2) @(posedge CORE_CLK);
    #1 ARST_N = 1'b1;
    r_got = {ACC, DEST_DATA, MEM_RD, DEST_WE, FLAG_C, FLAG_V, FLAG_Z, BUSY, DONE, BAD_OP};
    check(r_got, 24'h0);
    for (int p = 0; p < 4; p++) begin
      for (int op = 0; op < 18; op++) begin
        for (int f = 0; f < 5; f++) begin
          repeat (11) seed = lfsr(seed);
          issue(5'(op), 3'(f), pick(seed[9:0]), pick(seed[19:10]), pick(seed[29:20]),
                seed[31:16]);
        end
      end
      issue(5'h1F, 3'h1, seed[7:0], seed[15:8], 8'h00, 16'h0000);
    end
    repeat (2) @(posedge CORE_CLK);
    check(24'(exp_q.size()), 24'h0);
    conclude;
  end
endmodule
`default_nettype wire
